// [src/swc_pkg.sv]
// Package for the sleep/wake controller: states, wake sources, timing constants.
// Assumes a single 50 MHz core clock that keeps running during sleep, as this block needs it then.
package swc_pkg;

    localparam int unsigned CLK_MHZ         = 50;
    localparam int unsigned OST_TIME_US     = 20;
    localparam int unsigned OST_CYCLES      = OST_TIME_US * CLK_MHZ;
    localparam int unsigned OST_WIDTH       = 11;
    localparam int unsigned WDT_WIDTH       = 16;
    localparam int unsigned NUM_SRC         = 9;
    localparam int unsigned PC_WIDTH        = 13;
    localparam int unsigned DUMMY_CYCLES    = 2;
    localparam logic [PC_WIDTH-1:0] INT_VECTOR = 13'h0004;
    localparam logic [PC_WIDTH-1:0] PC_STEP    = 13'h0001;
    localparam logic [1:0] DUMMY_LAST          = 2'h1;

    // Wake-capable source indices
    localparam int unsigned SRC_ASYNC_TMR   = 0;
    localparam int unsigned SRC_CAPTURE     = 1;
    localparam int unsigned SRC_ADC_RC      = 2;
    localparam int unsigned SRC_EE_DONE     = 3;
    localparam int unsigned SRC_COMPARATOR  = 4;
    localparam int unsigned SRC_PIN_CHANGE  = 5;
    localparam int unsigned SRC_EXT_INT     = 6;
    localparam int unsigned SRC_BREAK       = 7;
    localparam int unsigned SRC_I2C_SLAVE   = 8;

    typedef enum logic [5:0] {
        SWC_RUN    = 6'h01,
        SWC_SLEEP  = 6'h02,
        SWC_OST    = 6'h04,
        SWC_PREF   = 6'h08,
        SWC_DUMMY  = 6'h10,
        SWC_VECTOR = 6'h20
    } swc_state_type;

endpackage

// [src/swc_wake_if.sv]
// Interface carrying the wake-source qualification between the two design modules.
// Assumes both ends share core_clk_i.
`timescale 1ns/100ps
interface swc_wake_if;
    import swc_pkg::*;
    logic [NUM_SRC-1:0] flag;
    logic [NUM_SRC-1:0] enable;
    logic               pending;
    modport ctrl (output flag, output enable, input  pending);
    modport qual (input  flag, input  enable, output pending);
endinterface

// [src/swc_wake_qual.sv]
// Qualifies wake-capable interrupt flags with their own enables.
// Assumes flags arrive already synchronised; global enable is not consulted.
`timescale 1ns/100ps
module swc_wake_qual
    import swc_pkg::*;
(
    swc_wake_if.qual wake
);
    logic [NUM_SRC-1:0] hit;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            assign hit[g] = wake.flag[g] & wake.enable[g]; // R11
        end
    endgenerate

    assign wake.pending = |hit; // R9
endmodule

// [src/swc_ctrl.sv]
// Sleep/wake controller: sleep entry, clock and pad hold, watchdog clear, wake flow.
// Assumes the core pulses sleep_exec_i while a sleep instruction executes, and
// that the external master-clear pin resets this block through resetn_i.
//
// Contract
// [R1] Sleep clears the watchdog; it keeps counting while asleep.
// [R2] Sleep entry clears power-down flag and sets timeout flag.
// [R3] Oscillator driver is off while asleep.
// [R4] Pads hold their pre-sleep state while asleep.
// [R5] Watchdog reset stays internal; master-clear pin is never driven.
// [R6] Wake on master clear (full reset), watchdog, or enabled interrupt.
// [R7] Watchdog wake clears the timeout flag.
// [R8] Power-down flag set at power-up, cleared on sleep entry.
// [R9] Only the nine listed asynchronous sources may wake the device.
// [R10] The instruction after sleep is prefetched during sleep.
// [R11] Interrupt wake needs the source enable, not the global enable.
// [R12] After interrupt wake run prefetched op, then vector if global enable.
// [R13] Software may place a no-op after sleep to skip the prefetched op.
// [R14] Watchdog is cleared on every wake, whatever the source.
// [R15] Enabled flag already set: sleep acts as no-op, nothing cleared.
// [R16] Flag set during sleep: finish sleep, clear watchdog, wake at once.
// [R17] Crystal clock wake holds watchdog cleared until start-up timer ends.
// [R18] Global-enable interrupt wake inserts two dummy cycles, then vector.
`timescale 1ns/100ps
module swc_ctrl
    import swc_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 por_i,
    input  wire logic                 sleep_exec_i,
    input  wire logic [PC_WIDTH-1:0]  pc_i,
    input  wire logic                 global_interrupt_enable_i,
    input  wire logic [NUM_SRC-1:0]   int_flag_i,
    input  wire logic [NUM_SRC-1:0]   int_enable_i,
    input  wire logic                 wdt_enable_i,
    input  wire logic                 clrwdt_i,
    input  wire logic                 crystal_osc_i,
    input  wire logic [WDT_WIDTH-1:0] wdt_period_i,
    input  wire logic                 lp_tick_i,
    output logic                      osc_driver_en_o,
    output logic                      pad_hold_o,
    output logic                      power_down_flag_n_o,
    output logic                      timeout_flag_n_o,
    output logic [WDT_WIDTH-1:0]      watchdog_counter_o,
    output logic                      wdt_reset_o,
    output logic                      master_clear_pin_oe_o,
    output logic                      core_stall_o,
    output logic                      prefetch_o,
    output logic [PC_WIDTH-1:0]       prefetch_addr_o,
    output logic                      exec_prefetched_o,
    output logic                      dummy_cycle_o,
    output logic                      vector_jump_o,
    output logic [PC_WIDTH-1:0]       vector_addr_o
);
    // Interrupt flags come from blocks that still run during sleep
    logic [NUM_SRC-1:0] flag_meta;
    logic [NUM_SRC-1:0] flag_sync;
    logic               tick_meta;
    logic               tick_sync;
    logic               tick_prev;
    logic               tick;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            flag_meta <= '0;
            flag_sync <= '0;
            tick_meta <= 1'b0;
            tick_sync <= 1'b0;
            tick_prev <= 1'b0;
        end else begin
            flag_meta <= int_flag_i;
            flag_sync <= flag_meta;
            tick_meta <= lp_tick_i;
            tick_sync <= tick_meta;
            tick_prev <= tick_sync;
        end
    end

    assign tick = tick_sync & ~tick_prev;

    swc_wake_if wake ();
    assign wake.flag   = flag_sync;
    assign wake.enable = int_enable_i;

    swc_wake_qual u_qual (
        .wake (wake)
    );

    swc_state_type        state;
    swc_state_type        next_state;
    logic                 pd_n;
    logic                 next_pd_n;
    logic                 to_n;
    logic                 next_to_n;
    logic [WDT_WIDTH-1:0] wdt;
    logic [WDT_WIDTH-1:0] next_wdt;
    logic [OST_WIDTH-1:0] oscillator_startup_timer;
    logic [OST_WIDTH-1:0] next_ost;
    logic [1:0]           dummy;
    logic [1:0]           next_dummy;
    logic [PC_WIDTH-1:0]  pref_addr;
    logic [PC_WIDTH-1:0]  next_pref_addr;
    logic                 wdt_rst;
    logic                 next_wdt_rst;
    logic                 wdt_expired;

    assign wdt_expired = wdt_enable_i && (wdt >= wdt_period_i);

    always_comb begin
        next_state     = state;
        next_pd_n      = pd_n;
        next_to_n      = to_n;
        next_wdt       = wdt;
        next_ost       = oscillator_startup_timer;
        next_dummy     = dummy;
        next_pref_addr = pref_addr;
        next_wdt_rst   = 1'b0;
        if (!wdt_enable_i || clrwdt_i) begin
            next_wdt = '0;
        end else if (tick) begin
            next_wdt = wdt + 1'b1;
        end
        case (state)
            SWC_RUN: begin
                if (sleep_exec_i && !wake.pending) begin // R15
                    next_wdt       = '0; // R1
                    next_pd_n      = 1'b0; // R2 R8
                    next_to_n      = 1'b1; // R2
                    next_pref_addr = pc_i + PC_STEP; // R10
                    next_state     = SWC_SLEEP;
                end else if (wdt_expired) begin
                    next_to_n    = 1'b0;
                    next_wdt     = '0;
                    next_wdt_rst = 1'b1; // R5
                end
            end
            SWC_SLEEP: begin
                if (wdt_expired || wake.pending) begin // R6 R16
                    if (wdt_expired) begin
                        next_to_n = 1'b0; // R7
                    end
                    next_wdt   = '0; // R14
                    next_ost   = '0;
                    next_state = crystal_osc_i ? SWC_OST : SWC_PREF;
                end
            end
            SWC_OST: begin
                next_wdt = '0; // R17
                if (oscillator_startup_timer == OST_WIDTH'(OST_CYCLES - 1)) begin
                    next_state = SWC_PREF;
                end else begin
                    next_ost = oscillator_startup_timer + 1'b1;
                end
            end
            SWC_PREF: begin
                next_dummy = '0;
                if (global_interrupt_enable_i && wake.pending) begin
                    next_state = SWC_DUMMY; // R12
                end else begin
                    next_state = SWC_RUN;
                end
            end
            SWC_DUMMY: begin
                if (dummy == DUMMY_LAST) begin
                    next_state = SWC_VECTOR; // R18
                end else begin
                    next_dummy = dummy + 1'b1;
                end
            end
            SWC_VECTOR: begin
                next_state = SWC_RUN;
            end
            default: begin
                next_state = SWC_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state     <= SWC_RUN;
            wdt       <= '0;
            oscillator_startup_timer       <= '0;
            dummy     <= '0;
            pref_addr <= '0;
            wdt_rst   <= 1'b0;
        end else begin
            state     <= next_state;
            wdt       <= next_wdt;
            oscillator_startup_timer       <= next_ost;
            dummy     <= next_dummy;
            pref_addr <= next_pref_addr;
            wdt_rst   <= next_wdt_rst;
        end
    end

    // Status flags survive master clear; power-on sets both, and sleep entry also sets to_n
    always_ff @(posedge core_clk_i) begin
        if (por_i) begin
            pd_n <= 1'b1; // R8
            to_n <= 1'b1;
        end else begin
            pd_n <= next_pd_n;
            to_n <= next_to_n;
        end
    end

    // The oscillator must run while waiting out the start-up timer
    assign osc_driver_en_o       = (state != SWC_SLEEP); // R3
    assign pad_hold_o            = (state == SWC_SLEEP) || (state == SWC_OST); // R4
    assign master_clear_pin_oe_o = 1'b0; // R5
    assign wdt_reset_o           = wdt_rst;
    assign power_down_flag_n_o   = pd_n;
    assign timeout_flag_n_o      = to_n;
    assign watchdog_counter_o    = wdt;
    assign core_stall_o          = (state == SWC_SLEEP) || (state == SWC_OST);
    assign prefetch_o            = (state == SWC_SLEEP);
    assign prefetch_addr_o       = pref_addr;
    assign exec_prefetched_o     = (state == SWC_PREF); // R12
    assign dummy_cycle_o         = (state == SWC_DUMMY);
    assign vector_jump_o         = (state == SWC_VECTOR);
    assign vector_addr_o         = INT_VECTOR;
endmodule

// [test/swc_ctrl_asserts.sv]
// Port-level checker for the sleep/wake controller.
// Assumes sleep is only issued from the run state.
`timescale 1ns/100ps
module swc_ctrl_asserts
    import swc_pkg::*;
(
    input wire logic                 core_clk_i,
    input wire logic                 resetn_i,
    input wire logic                 sleep_exec_i,
    input wire logic [PC_WIDTH-1:0]  pc_i,
    input wire logic [NUM_SRC-1:0]   int_flag_i,
    input wire logic [NUM_SRC-1:0]   int_enable_i,
    input wire logic                 osc_driver_en_o,
    input wire logic                 pad_hold_o,
    input wire logic                 power_down_flag_n_o,
    input wire logic                 timeout_flag_n_o,
    input wire logic [WDT_WIDTH-1:0] watchdog_counter_o,
    input wire logic                 master_clear_pin_oe_o,
    input wire logic                 core_stall_o,
    input wire logic                 prefetch_o,
    input wire logic [PC_WIDTH-1:0]  prefetch_addr_o,
    input wire logic                 dummy_cycle_o,
    input wire logic                 vector_jump_o,
    input wire logic [PC_WIDTH-1:0]  vector_addr_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Four cycles cover the flag synchroniser latency
    sequence s_quiet; (~|(int_flag_i & int_enable_i))[*4]; endsequence
    sequence s_pend; (|(int_flag_i & int_enable_i))[*4]; endsequence
    sequence s_vec; vector_jump_o && vector_addr_o == INT_VECTOR; endsequence
    chk_entry_flags: assert property (s_quiet ##0 (sleep_exec_i && !core_stall_o) |=>
        !osc_driver_en_o && !power_down_flag_n_o && timeout_flag_n_o && watchdog_counter_o == '0)
        else $error("sleep entry state wrong");
    chk_hold_pads: assert property (!osc_driver_en_o |-> pad_hold_o && core_stall_o)
        else $error("pads not held in sleep");
    chk_master_clear_pin_quiet: assert property (master_clear_pin_oe_o == 1'b0)
        else $error("master clear pin driven");
    chk_prefetch_addr: assert property ($rose(prefetch_o) |->
        prefetch_addr_o == $past(pc_i) + PC_STEP)
        else $error("prefetch address wrong");
    chk_wake_wdt: assert property ($fell(core_stall_o) |-> watchdog_counter_o == '0)
        else $error("watchdog not cleared on wake");
    chk_ost_wdt: assert property (core_stall_o && osc_driver_en_o |->
        watchdog_counter_o == '0)
        else $error("watchdog counts during start-up");
    chk_vector_seq: assert property ($rose(dummy_cycle_o) |->
        dummy_cycle_o[*2] ##1 s_vec ##1 !vector_jump_o)
        else $error("dummy and vector order wrong");
    chk_sleep_noop: assert property (s_pend ##0 (sleep_exec_i && !core_stall_o) |=>
        osc_driver_en_o && $stable(power_down_flag_n_o) && $stable(timeout_flag_n_o))
        else $error("pending sleep not a no-op");
endmodule

// [test/swc_src_model.sv]
// Far-side model: wake-capable interrupt sources and the low-power tick.
// Assumes the bench requests flags through raise_i.
`timescale 1ns/100ps
module swc_src_model
    import swc_pkg::*;
(
    input  wire logic [NUM_SRC-1:0] raise_i,
    output logic                    lp_tick_o,
    output logic [NUM_SRC-1:0]      int_flag_o
);
    // Free-running at 13 core periods and rising on core rising edges; it passes through the synchroniser
    initial begin
        lp_tick_o = 1'b0;
        forever #130 lp_tick_o = ~lp_tick_o;
    end
    // Flags land off the core edge, as their sources are not clocked by the core
    initial begin
        int_flag_o = '0;
        forever begin
            @(raise_i);
            int_flag_o <= #7 raise_i;
        end
    end
endmodule

// [test/swc_tb_top.sv]
// Top bench for the sleep/wake controller: entry, no-op, every wake path.
// Assumes the source model supplies flags and the low-power tick.
`timescale 1ns/100ps
module swc_tb_top
    import swc_pkg::*;
;
    logic core_clk_i = 1'b0, resetn_i, por_i, sleep_exec_i, global_interrupt_enable_i;
    logic wdt_enable_i, clrwdt_i, crystal_osc_i, lp_tick_i, osc_driver_en_o, pad_hold_o;
    logic power_down_flag_n_o, timeout_flag_n_o, wdt_reset_o, master_clear_pin_oe_o;
    logic core_stall_o, prefetch_o, exec_prefetched_o, dummy_cycle_o, vector_jump_o;
    logic [PC_WIDTH-1:0]  pc_i, prefetch_addr_o, vector_addr_o;
    logic [NUM_SRC-1:0]   raise_i, int_flag_i, int_enable_i;
    logic [WDT_WIDTH-1:0] wdt_period_i, watchdog_counter_o;
    int                   errors = 0, n_checks = 0;
    swc_ctrl dut (.*);
    swc_src_model u_src (.raise_i(raise_i), .lp_tick_o(lp_tick_i), .int_flag_o(int_flag_i));
    initial forever #10 core_clk_i = ~core_clk_i;
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic go_sleep();
        @(posedge core_clk_i) sleep_exec_i <= 1'b1;
        @(posedge core_clk_i) sleep_exec_i <= 1'b0;
        #1 check("sleep_wdt", 16'h0000, watchdog_counter_o);
    endtask
    task automatic t_noop();
        @(posedge core_clk_i) int_enable_i <= 9'h020;
        raise_i <= 9'h020;
        repeat (6) @(posedge core_clk_i);
        go_sleep();
        check("noop_osc", 16'h0001, osc_driver_en_o);
        check("noop_pd_n", 16'h0001, power_down_flag_n_o);
        check("noop_to_n", 16'h0001, timeout_flag_n_o);
        @(posedge core_clk_i) raise_i <= '0;
        int_enable_i <= '0;
        repeat (6) @(posedge core_clk_i);
    endtask
    task automatic t_master_clear_pin();
        go_sleep();
        @(posedge core_clk_i) resetn_i <= 1'b0;
        @(posedge core_clk_i) resetn_i <= 1'b1;
        #1 check("master_clear_pin_osc", 16'h0001, osc_driver_en_o);
    endtask
    // Odd sources wake with global enable set; the last one uses crystal start-up
    task automatic t_int(input int s);
        @(posedge core_clk_i) global_interrupt_enable_i <= s[0];
        crystal_osc_i <= (s == 8);
        wdt_enable_i  <= (s == 8);
        go_sleep();
        check("pf_addr", 16'h0a01, prefetch_addr_o);
        check("pd_n", 16'h0000, power_down_flag_n_o);
        check("to_n", 16'h0001, timeout_flag_n_o);
        check("hold", 16'h0001, pad_hold_o);
        check("osc_off", 16'h0000, osc_driver_en_o);
        check("prefetch", 16'h0001, prefetch_o);
        @(posedge core_clk_i) raise_i <= 9'h001 << s;
        repeat (10) @(posedge core_clk_i);
        #1 check("masked_stall", 16'h0001, core_stall_o);
        @(posedge core_clk_i) int_enable_i <= 9'h001 << s;
        for (int i = 0; i < 1200 && exec_prefetched_o !== 1'b1; i++) @(posedge core_clk_i) #1;
        check("exec_pf", 16'h0001, exec_prefetched_o);
        check("wake_wdt", 16'h0000, watchdog_counter_o);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk_i) #1;
            check("dummy", s[0], dummy_cycle_o);
        end
        @(posedge core_clk_i) #1 check("vector", s[0], vector_jump_o);
        check("vec_addr", 16'h0004, vector_addr_o);
        @(posedge core_clk_i) raise_i <= '0;
        int_enable_i <= '0;
        wdt_enable_i <= 1'b0;
    endtask
    // Expiry while running resets the core internally only
    task automatic t_wdt_run();
        @(posedge core_clk_i) wdt_enable_i <= 1'b1;
        repeat (40) @(posedge core_clk_i);
        #1 check("wdt_run", 16'h0001, watchdog_counter_o != '0);
        @(posedge core_clk_i) clrwdt_i <= 1'b1;
        @(posedge core_clk_i) clrwdt_i <= 1'b0;
        #1 check("clrwdt", 16'h0000, watchdog_counter_o);
        for (int i = 0; i < 300 && wdt_reset_o !== 1'b1; i++) @(posedge core_clk_i) #1;
        check("wdt_rst", 16'h0001, wdt_reset_o);
        check("wdt_rst_to_n", 16'h0000, timeout_flag_n_o);
        check("wdt_rst_pd_n", 16'h0000, power_down_flag_n_o);
        check("wdt_rst_pin", 16'h0000, master_clear_pin_oe_o);
        @(posedge core_clk_i) #1 check("wdt_rst_pulse", 16'h0000, wdt_reset_o);
        @(posedge core_clk_i) wdt_enable_i <= 1'b0;
    endtask
    task automatic t_wdt();
        @(posedge core_clk_i) wdt_enable_i <= 1'b1;
        crystal_osc_i <= 1'b0;
        go_sleep();
        repeat (60) @(posedge core_clk_i);
        #1 check("wdt_counts", 16'h0001, watchdog_counter_o != '0);
        for (int i = 0; i < 400 && core_stall_o !== 1'b0; i++) @(posedge core_clk_i) #1;
        check("wdt_to_n", 16'h0000, timeout_flag_n_o);
        check("wdt_clear", 16'h0000, watchdog_counter_o);
        @(posedge core_clk_i) wdt_enable_i <= 1'b0;
    endtask
    initial begin
        {resetn_i, sleep_exec_i, global_interrupt_enable_i, wdt_enable_i} = '0;
        {clrwdt_i, crystal_osc_i, pc_i, raise_i, int_enable_i} = '0;
        por_i        = 1'b1;
        pc_i         = 13'h0a00;
        wdt_period_i = 16'h0008;
        repeat (20) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        por_i    <= 1'b0;
        @(posedge core_clk_i) #1 check("por_pd_n", 16'h0001, power_down_flag_n_o);
        check("por_to_n", 16'h0001, timeout_flag_n_o);
        t_noop();
        t_master_clear_pin();
        for (int s = 0; s < NUM_SRC; s++) t_int(s);
        t_wdt_run();
        t_wdt();
        conclude();
    end
    // Whole run needs about 1500 cycles
    initial begin
        #400000;
        errors++;
        conclude();
    end
endmodule
bind swc_ctrl swc_ctrl_asserts u_chk (.*);
